/* File: hw/psf_core.sv */
// Fault detection and clearing logic of a four-channel power supply sequencer.
// Assumes comparator results arrive as asynchronous levels and open-drain pins are
// resolved outside; an oe_n low means the pin is pulled low or driven.
//
// What this block does (RULE10 and RULE12 are what it expects of the controller)
// (RULE1) Any fault forces all supply enables low.
// (RULE2) Own-supply fault pulls fault line low.
// (RULE3) Leave fault only when inputs low; line must also be free after an external fault.
// (RULE4) Commanded fault pulls delay timer pin low.
// (RULE5) Self-detected fault raises delay timer pin high.
// (RULE6) Indication holds until on command drops.
// (RULE7) Expected-on supply reading low is a fault.
// (RULE8) Sense inputs use sampled precision comparator.
// (RULE9) Fast low comparator faults within one microsecond.
// (RULE10) Controller holds on high until done.
// (RULE11) On dropped during power-on is a fault.
// (RULE12) Controller holds on low until off done.
// (RULE13) On raised during power-off is a fault.
// (RULE14) Power-good timeout during power-on is a fault.
// (RULE15) External fault: hold line low until cleared.
// (RULE16) Sense high marks supply on, start delay.
// (RULE17) Last supply on turns on completion pull-down.
// (RULE18) Power-off in reverse order, then release completion.
// (RULE19) Start power-good timer per enable, reset on sense.
// (RULE20) State machine with latched fault state.
`timescale 1ns/100ps
module psf_core #(
   parameter int NUM_SUP = psf_pkg::NUM_SUP,
   parameter int DELAY_CYC = psf_pkg::DELAY_CYC_DEF,
   parameter int SAMPLE_CYC = psf_pkg::SAMPLE_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic on_cmd_i,
   input wire logic [NUM_SUP-1:0] supply_sense_above_i,
   input wire logic [NUM_SUP-1:0] supply_sense_fast_low_i,
   input wire logic power_good_timeout_over_i,
   input wire logic fault_line_i,
   output logic [NUM_SUP-1:0] supply_enable_o,
   output logic fault_line_oe_n_o,
   output logic done_oe_n_o,
   output logic delay_timer_o,
   output logic delay_timer_oe_n_o,
   output logic power_good_timer_run_o
);

   localparam int IDX_W = $clog2(NUM_SUP);
   localparam int CW = psf_pkg::CNT_W;
   localparam int RW = psf_pkg::REL_W;
   localparam int SW = 2 * NUM_SUP + 3;

   typedef struct packed {
      psf_pkg::psf_fsm_t state;
      logic [NUM_SUP-1:0] en;
      logic [NUM_SUP-1:0] up;
      logic [IDX_W-1:0] idx;
      logic [CW-1:0] cnt;
      logic [RW-1:0] rel;
      logic ext;
      logic run;
      logic done_oe_n;
      logic fault_oe_n;
      logic tmr_val;
      logic tmr_oe_n;
   } psf_state_t;

   localparam psf_state_t ST_RST = '{
      state: psf_pkg::PSF_IDLE,
      en: {NUM_SUP{psf_pkg::EN_RST}},
      up: '0,
      idx: '0,
      cnt: '0,
      rel: '0,
      ext: 1'b0,
      run: 1'b0,
      done_oe_n: psf_pkg::OE_N_RST,
      fault_oe_n: psf_pkg::OE_N_RST,
      tmr_val: 1'b0,
      tmr_oe_n: psf_pkg::OE_N_RST
   };

   psf_state_t st;
   psf_state_t next_st;

   logic [SW-1:0] sync_v;
   logic [NUM_SUP-1:0] s_hi;
   logic [NUM_SUP-1:0] fast_low;
   logic on_s;
   logic tmo_s;
   logic line_low;
   logic ext_seen;
   logic seq_err;
   logic int_flt;
   logic clr_ok;
   logic in_pon;
   logic in_poff;
   logic active;

   generate
      if (NUM_SUP < 2 || NUM_SUP > 8) begin : g_chk_n
         $error("psf_core: supply count must be between two and eight");
      end
      if (DELAY_CYC < 1 || DELAY_CYC >= (1 << psf_pkg::CNT_W)) begin : g_chk_d
         $error("psf_core: step delay does not fit the delay counter");
      end
   endgenerate

   // Every pin level passes two flops before any decision reads it.
   psf_sync #(
      .W(SW)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .async_i({supply_sense_above_i, supply_sense_fast_low_i, on_cmd_i,
                power_good_timeout_over_i, fault_line_i}),
      .sync_o(sync_v)
   );

   // The precision threshold is only evaluated at sample instants.
   psf_sampler #(
      .W(NUM_SUP),
      .PERIOD(SAMPLE_CYC)
   ) u_sampler (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .level_i(sync_v[SW-1 -: NUM_SUP]),
      .held_o(s_hi)
   );

   // Unpack the synchronised levels.
   assign fast_low = sync_v[NUM_SUP+2:3];
   assign on_s = sync_v[2];
   assign tmo_s = sync_v[1];
   assign line_low = ~sync_v[0];

   // Phase decoding shared by the fault detectors.
   assign in_pon = (st.state == psf_pkg::PSF_PON_WAIT) || (st.state == psf_pkg::PSF_PON_DLY);
   assign in_poff = (st.state == psf_pkg::PSF_POFF_DLY) || (st.state == psf_pkg::PSF_POFF_WAIT);
   assign active = (st.state != psf_pkg::PSF_IDLE) && (st.state != psf_pkg::PSF_FAULT);

   // Our own pull-down echoes back through the synchroniser, so a low line is only
   // taken as external once it has been released for the settle time.
   assign ext_seen = line_low && st.fault_oe_n && (st.rel == RW'(psf_pkg::SETTLE_CYC));

   // A supply marked up that reads low on either comparator is a sequence error.
   assign seq_err = |(st.up & (~s_hi | fast_low)); // RULE7 RULE9

   // Internal fault sources, grouped by the phase in which each one counts.
   assign int_flt = (active && seq_err)
                  || (in_pon && !on_s) // RULE11
                  || (in_poff && on_s) // RULE13
                  || ((st.state == psf_pkg::PSF_PON_WAIT) && tmo_s); // RULE14

   // Clearing needs every sense input and the on command below threshold.
   assign clr_ok = !(|s_hi) && !on_s; // RULE3

   // Next-state logic of the sequencer and its latched fault state.
   always_comb begin
      next_st = st;
      // Settle counter restarts whenever the line is pulled by us.
      if (!st.fault_oe_n) begin
         next_st.rel = '0;
      end else if (st.rel != RW'(psf_pkg::SETTLE_CYC)) begin
         next_st.rel = st.rel + 1'b1;
      end
      // A supply is up once its enable is set and its sense reads high.
      next_st.up = (st.up | s_hi) & st.en; // RULE16
      if (st.state != psf_pkg::PSF_FAULT && (int_flt || ext_seen)) begin
         // Internal wins when both appear together, since our own supply is the cause.
         next_st.state = psf_pkg::PSF_FAULT; // RULE20
         next_st.en = '0; // RULE1
         next_st.up = '0;
         next_st.run = 1'b0;
         next_st.done_oe_n = 1'b1;
         next_st.fault_oe_n = 1'b0; // RULE2 RULE15
         next_st.ext = !int_flt;
         next_st.tmr_val = int_flt; // RULE4 RULE5
         next_st.tmr_oe_n = 1'b0;
      end else begin
         case (st.state)
            psf_pkg::PSF_IDLE: begin
               if (on_s) begin
                  next_st.idx = '0;
                  next_st.en[0] = 1'b1;
                  next_st.run = 1'b1; // RULE19
                  next_st.state = psf_pkg::PSF_PON_WAIT;
               end
            end
            psf_pkg::PSF_PON_WAIT: begin
               if (s_hi[st.idx]) begin
                  next_st.run = 1'b0; // RULE19
                  if (st.idx == IDX_W'(NUM_SUP - 1)) begin
                     next_st.done_oe_n = 1'b0; // RULE17
                     next_st.state = psf_pkg::PSF_ON;
                  end else begin
                     next_st.cnt = CW'(DELAY_CYC); // RULE16
                     next_st.state = psf_pkg::PSF_PON_DLY;
                  end
               end
            end
            psf_pkg::PSF_PON_DLY: begin
               if (st.cnt == '0) begin
                  next_st.idx = st.idx + 1'b1;
                  next_st.en[st.idx + 1'b1] = 1'b1;
                  next_st.run = 1'b1; // RULE19
                  next_st.state = psf_pkg::PSF_PON_WAIT;
               end else begin
                  next_st.cnt = st.cnt - 1'b1;
               end
            end
            psf_pkg::PSF_ON: begin
               if (!on_s) begin
                  next_st.idx = IDX_W'(NUM_SUP - 1);
                  next_st.cnt = CW'(DELAY_CYC);
                  next_st.state = psf_pkg::PSF_POFF_DLY;
               end
            end
            psf_pkg::PSF_POFF_DLY: begin
               // No power-good timing is kept while sequencing down.
               if (st.cnt == '0) begin
                  next_st.en[st.idx] = 1'b0; // RULE18
                  next_st.up[st.idx] = 1'b0;
                  next_st.state = psf_pkg::PSF_POFF_WAIT;
               end else begin
                  next_st.cnt = st.cnt - 1'b1;
               end
            end
            psf_pkg::PSF_POFF_WAIT: begin
               if (!s_hi[st.idx]) begin
                  if (st.idx == '0) begin
                     next_st.done_oe_n = 1'b1; // RULE18
                     next_st.state = psf_pkg::PSF_IDLE;
                  end else begin
                     next_st.idx = st.idx - 1'b1;
                     next_st.cnt = CW'(DELAY_CYC);
                     next_st.state = psf_pkg::PSF_POFF_DLY;
                  end
               end
            end
            psf_pkg::PSF_FAULT: begin
               next_st.en = '0; // RULE1
               // The line is let go once the local conditions clear, so an outside
               // holder becomes visible; it is pulled again if they break.
               next_st.fault_oe_n = clr_ok; // RULE15
               if (clr_ok && (!st.ext || (st.fault_oe_n && !line_low
                              && st.rel == RW'(psf_pkg::SETTLE_CYC)))) begin
                  // The indicator lives until here, which already needs on low.
                  next_st.state = psf_pkg::PSF_IDLE; // RULE3 RULE6
                  next_st.tmr_oe_n = 1'b1;
                  next_st.tmr_val = 1'b0;
                  next_st.ext = 1'b0;
                  next_st.fault_oe_n = 1'b1;
               end
            end
            default: begin
               next_st = ST_RST;
            end
         endcase
      end
   end

   // All state registers in one place; outputs come straight from these flops.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= ST_RST;
      end else begin
         st <= next_st;
      end
   end

   assign supply_enable_o = st.en;
   assign fault_line_oe_n_o = st.fault_oe_n;
   assign done_oe_n_o = st.done_oe_n;
   assign delay_timer_o = st.tmr_val;
   assign delay_timer_oe_n_o = st.tmr_oe_n;
   assign power_good_timer_run_o = st.run;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_fault_int;
      st.state == psf_pkg::PSF_FAULT && !st.fault_oe_n && !st.ext;
   endsequence

   sequence s_first_on;
      st.state == psf_pkg::PSF_PON_WAIT && st.en[0] && st.run;
   endsequence

   sequence s_step_done;
      !st.run ##0 (st.state == psf_pkg::PSF_PON_DLY || st.state == psf_pkg::PSF_ON);
   endsequence

   a_fault_no_enables: assert property (st.state == psf_pkg::PSF_FAULT |-> st.en == '0) // RULE1
      else $error("Supply enable high in fault state.");
   a_int_line_low: assert property ($rose(st.state == psf_pkg::PSF_FAULT) && !st.ext
      |-> !st.fault_oe_n) // RULE2
      else $error("Internal fault did not pull the fault line.");
   a_clear_quiet: assert property (st.state == psf_pkg::PSF_FAULT
      ##1 st.state == psf_pkg::PSF_IDLE |-> $past(clr_ok)) // RULE3
      else $error("Fault cleared while inputs were still high.");
   a_ext_timer_low: assert property (st.state == psf_pkg::PSF_FAULT && st.ext
      |-> !st.tmr_oe_n && !st.tmr_val) // RULE4
      else $error("Commanded fault not shown low on delay timer pin.");
   a_int_timer_high: assert property (st.state == psf_pkg::PSF_FAULT && !st.ext
      |-> !st.tmr_oe_n && st.tmr_val) // RULE5
      else $error("Own fault not shown high on delay timer pin.");
   a_ind_hold: assert property (st.state == psf_pkg::PSF_FAULT && on_s
      |=> !st.tmr_oe_n) // RULE6
      else $error("Fault indication dropped while on command high.");
   a_seq_error: assert property (active && |(st.up & ~s_hi)
      |=> st.state == psf_pkg::PSF_FAULT) // RULE7
      else $error("Sequence error did not enter the fault state.");
   a_fast_low: assert property (active && |(st.up & fast_low)
      |=> s_fault_int) // RULE9
      else $error("Fast low supply did not raise an internal fault.");
   a_on_drop: assert property (in_pon && !on_s |=> s_fault_int) // RULE11
      else $error("On command withdrawal during power-on missed.");
   a_on_rise: assert property (in_poff && on_s |=> s_fault_int) // RULE13
      else $error("On command rise during power-off missed.");
   a_timeout: assert property (st.state == psf_pkg::PSF_PON_WAIT && tmo_s
      |=> s_fault_int) // RULE14
      else $error("Power-good timeout missed.");
   a_ext_hold: assert property (st.state == psf_pkg::PSF_FAULT && st.ext && !clr_ok
      |=> !st.fault_oe_n) // RULE15
      else $error("Fault line released before clearing conditions.");
   a_pon_start: assert property (st.state == psf_pkg::PSF_IDLE && on_s && !ext_seen
      |=> s_first_on) // RULE19
      else $error("Power-on did not enable the first supply.");
   a_step_reset: assert property (st.state == psf_pkg::PSF_PON_WAIT && s_hi[st.idx]
      && !int_flt && !ext_seen |=> s_step_done) // RULE16 RULE19
      else $error("Supply on did not reset the power-good timer.");
   a_done_on: assert property (st.state == psf_pkg::PSF_ON |-> !st.done_oe_n) // RULE17
      else $error("Completion pull-down off after power-on.");
   a_poff_done: assert property (st.state == psf_pkg::PSF_POFF_WAIT && st.idx == '0
      && !s_hi[0] && !int_flt && !ext_seen
      |=> st.done_oe_n && st.state == psf_pkg::PSF_IDLE) // RULE18
      else $error("Completion not released at end of power-off.");

endmodule

/* File: hw/psf_pkg.sv */
// Shared constants and the state encoding of the supply sequencer fault logic.
// Assumes a single 125 MHz system clock; all times below are converted to cycles of it.
package psf_pkg;

   // System clock rate in hertz.
   localparam int CLK_HZ = 125_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;

   // Number of sequenced supplies.
   localparam int NUM_SUP = 4;

   // Precision comparator sample period, about 20 us; a longest time, so it rounds down.
   localparam int SAMPLE_NS = 20_000;
   localparam int SAMPLE_CYC = SAMPLE_NS * CLK_MHZ / 1000;

   // Fast low-supply comparator reaction bound, about 1 us; rounds down.
   localparam int FAST_NS = 1_000;
   localparam int FAST_CYC = FAST_NS * CLK_MHZ / 1000;

   // Default delay between sequencing steps, in cycles.
   localparam int DELAY_CYC_DEF = 1000;

   // Delay counter width.
   localparam int CNT_W = 16;

   // Cycles after releasing the fault line before its sensed level is trusted again.
   localparam int SETTLE_CYC = 3;
   localparam int REL_W = 2;

   // Reset values of the open-drain enables and of the supply enables.
   localparam logic OE_N_RST = 1'b1;
   localparam logic EN_RST = 1'b0;

   // Sequencer states.
   typedef enum logic [2:0] {
      PSF_IDLE      = 3'h0,
      PSF_PON_WAIT  = 3'h1,
      PSF_PON_DLY   = 3'h2,
      PSF_ON        = 3'h3,
      PSF_POFF_DLY  = 3'h4,
      PSF_POFF_WAIT = 3'h5,
      PSF_FAULT     = 3'h6
   } psf_fsm_t;

endpackage

/* File: hw/psf_sync.sv */
// Two-flop synchroniser for a vector of asynchronous comparator and pin levels.
// Assumes each bit is an independent level; no multi-bit coherence is offered.
`timescale 1ns/100ps
module psf_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } psf_sync_t;

   psf_sync_t st;
   psf_sync_t next_st;

   generate
      if (W < 1) begin : g_chk
         $error("psf_sync: width must be at least one");
      end
   endgenerate

   // The first stage feeds only the second stage, so metastability never reaches logic.
   always_comb begin
      next_st.s1 = async_i;
      next_st.s2 = st.s1;
   end

   // Reset to all low; the inputs settle within two edges after release.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_o = st.s2;

endmodule

/* File: hw/psf_sampler.sv */
// Sampled precision comparator model: holds the sense levels between sample instants.
// Assumes its input is already synchronised to the system clock.
`timescale 1ns/100ps
module psf_sampler #(
   parameter int W = 4,
   parameter int PERIOD = psf_pkg::SAMPLE_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] level_i,
   output logic [W-1:0] held_o
);

   localparam int PW = $clog2(PERIOD);

   typedef struct packed {
      logic [PW-1:0] cnt;
      logic [W-1:0] held;
   } psf_smp_t;

   psf_smp_t st;
   psf_smp_t next_st;
   logic strobe;

   generate
      if (PERIOD < 2 || W < 1) begin : g_chk
         $error("psf_sampler: period must be at least two cycles");
      end
   endgenerate

   // Sampling trades reaction time for accuracy; the fast path covers the gap.
   always_comb begin
      next_st = st;
      strobe = (st.cnt == PW'(PERIOD - 1));
      if (strobe) begin
         next_st.cnt = '0;
         next_st.held = level_i; // RULE8
      end else begin
         next_st.cnt = st.cnt + 1'b1;
      end
   end

   // Counter and held levels clear at reset, so all supplies read as off.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign held_o = st.held;

   // The held value only moves on the cycle after a sample instant.
   a_sample_period: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !$stable(st.held) |-> $past(strobe)) // RULE8
      else $error("Held sense level changed outside a sample instant.");

endmodule

/* File: verif/psf_supply_model.sv */
// Model of the four sequenced supplies and of the power-good timing capacitor.
// Assumes the sequencer drives the enables; the bench steers stalls and sense faults.
`timescale 1ns/100ps
module psf_supply_model (
   input wire logic clk_sys_i,
   input wire logic [3:0] enable_i,
   input wire logic [3:0] stall_i,
   input wire logic [3:0] sag_i,
   input wire logic [3:0] crash_i,
   input wire logic timer_run_i,
   output logic [3:0] sense_above_o,
   output logic [3:0] sense_fast_low_o,
   output logic timeout_over_o
);
   int lvl [4] = '{0, 0, 0, 0};
   int power_good_timeout_pin = 0;

   // Supplies ramp at a random pace, so the sense timing differs from step to step.
   // A disabled supply decays slowly, which is what makes power-off take real time.
   always @(posedge clk_sys_i) begin
      for (int i = 0; i < 4; i++) begin
         if (enable_i[i] && !stall_i[i] && lvl[i] < 30) begin
            lvl[i] <= lvl[i] + 1 + int'($urandom % 2);
         end else if (!enable_i[i] && lvl[i] > 0) begin
            lvl[i] <= lvl[i] - 1;
         end
      end
      power_good_timeout_pin <= timer_run_i ? power_good_timeout_pin + 1 : 0; // The capacitor is shorted whenever the timer is off.
   end

   // A sag drops below the precision threshold only; a crash falls below the fast one too.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         sense_above_o[i] = (lvl[i] >= 12) && !sag_i[i] && !crash_i[i];
         sense_fast_low_o[i] = (lvl[i] < 5) || crash_i[i];
      end
      timeout_over_o = (power_good_timeout_pin > 100);
   end
endmodule

/* File: verif/tb_power_sequencer_fault_logic.sv */
// Self-checking bench of the sequencer fault logic with a supply model on the far side.
// Assumes short step delay and sample period parameters; the bench plays the controller.
`timescale 1ns/100ps
module tb_power_sequencer_fault_logic;
   localparam int DLY = 4;
   localparam int SMP = 8;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic on_cmd = 1'b0;
   logic ext_pull = 1'b0;
   logic [3:0] stall = 4'h0;
   logic [3:0] sag = 4'h0;
   logic [3:0] crash = 4'h0;
   logic [3:0] sense_above;
   logic [3:0] fast_low;
   logic [3:0] enable;
   logic tmo;
   logic fault_oe_n;
   logic done_oe_n;
   logic dt;
   logic dt_oe_n;
   logic run;
   logic [7:0] st;
   wire logic fault_line;
   int fails = 0;
   int compares = 0;
   int k;

   // The shared fault wire is pulled up and may be pulled low by either party.
   assign fault_line = !(fault_oe_n === 1'b0 || ext_pull);
   assign st = {fault_oe_n, done_oe_n, dt_oe_n, dt, enable};

   // Free-running system clock.
   always #4 clk_sys_i = ~clk_sys_i;

   psf_core #(.NUM_SUP(4), .DELAY_CYC(DLY), .SAMPLE_CYC(SMP)) dut (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .on_cmd_i(on_cmd),
      .supply_sense_above_i(sense_above),
      .supply_sense_fast_low_i(fast_low),
      .power_good_timeout_over_i(tmo),
      .fault_line_i(fault_line),
      .supply_enable_o(enable),
      .fault_line_oe_n_o(fault_oe_n),
      .done_oe_n_o(done_oe_n),
      .delay_timer_o(dt),
      .delay_timer_oe_n_o(dt_oe_n),
      .power_good_timer_run_o(run)
   );

   psf_supply_model partner (
      .clk_sys_i(clk_sys_i),
      .enable_i(enable),
      .stall_i(stall),
      .sag_i(sag),
      .crash_i(crash),
      .timer_run_i(run),
      .sense_above_o(sense_above),
      .sense_fast_low_o(fast_low),
      .timeout_over_o(tmo)
   );

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp,
                        input logic [7:0] mask);
      compares++;
      if ((seen & mask) !== (exp & mask)) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp & mask, seen & mask);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   // Bounded wait; a miss shows up in the comparison that follows.
   task automatic wait_st(input logic [7:0] exp, input logic [7:0] mask, input int lim);
      for (int i = 0; i < lim && (st & mask) !== (exp & mask); i++) step(1);
   endtask

   task automatic finish_test();
      if (fails == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic power_on();
      on_cmd = 1'b1;
      wait_st(8'hAF, 8'hEF, 400);
      check("power on", st, 8'hAF, 8'hEF);
      check("timer idle", {7'h0, run}, 8'h00, 8'h01);
   endtask

   task automatic to_idle(input string what);
      on_cmd = 1'b0;
      wait_st(8'hE0, 8'hEF, 600);
      check(what, st, 8'hE0, 8'hEF);
   endtask

   // Enables must always form a prefix of the supplies, which fixes the order both ways.
   always @(enable) begin
      if (rst_n_i) check("order", {4'h0, enable}, 8'((1 << $countones(enable)) - 1), 8'h0F);
   end

   // Hang guard sized well above the expected run of under two thousand cycles.
   initial begin
      #400_000;
      fails++;
      finish_test();
   end

   // Main sequence: normal cycle, then each fault source followed by its clearing.
   initial begin
      void'($urandom(32'h9e279324));
      step(10);
      rst_n_i = 1'b1;
      step(1);
      check("reset", st, 8'hE0, 8'hEF);
      power_on();
      to_idle("power off");
      // Sampled sag first, then a crash that only the fast comparator sees in time.
      for (int kind = 0; kind < 2; kind++) begin
         power_on();
         k = int'($urandom % 4);
         if (kind == 0) begin
            sag[k] = 1'b1;
            wait_st(8'h50, 8'hFF, 40);
         end else begin
            crash[k] = 1'b1;
            step(4);
         end
         check("sequence error", st, 8'h50, 8'hFF);
         step(50);
         check("indication held", st, 8'h50, 8'hFF);
         sag = 4'h0;
         crash = 4'h0;
         to_idle("sequence error clear");
      end
      // On command withdrawn in the middle of power-on.
      on_cmd = 1'b1;
      wait_st(8'h03, 8'h0F, 200);
      on_cmd = 1'b0;
      wait_st(8'h50, 8'hFF, 20);
      check("early off", st, 8'h50, 8'hFF);
      to_idle("early off clear");
      // On command raised again in the middle of power-off.
      power_on();
      on_cmd = 1'b0;
      wait_st(8'h07, 8'h0F, 200);
      on_cmd = 1'b1;
      wait_st(8'h50, 8'hFF, 20);
      check("early on", st, 8'h50, 8'hFF);
      to_idle("early on clear");
      // A stalled supply lets the power-good timer run out.
      stall[int'($urandom % 4)] = 1'b1;
      on_cmd = 1'b1;
      wait_st(8'h01, 8'h0F, 20);
      check("timer run", {7'h0, run}, 8'h01, 8'h01);
      wait_st(8'h50, 8'hFF, 400);
      check("timeout", st, 8'h50, 8'hFF);
      check("timer stop", {7'h0, run}, 8'h00, 8'h01);
      stall = 4'h0;
      to_idle("timeout clear");
      // Fault line pulled low from outside and held through the clearing attempt.
      power_on();
      ext_pull = 1'b1;
      wait_st(8'h40, 8'hFF, 20);
      check("external fault", st, 8'h40, 8'hFF);
      on_cmd = 1'b0;
      step(100);
      check("external held", st, 8'h40, 8'h7F);
      ext_pull = 1'b0;
      to_idle("external clear");
      finish_test();
   end
endmodule
